// ==== rtl/cdr_pkg.sv ====
package cdr_pkg;

   // Storage geometry of the block: 4096 bits held as 256 words of 16 bits.
   localparam int unsigned CDR_TOTAL_BITS = 4096;
   localparam int unsigned CDR_WORD_W = 16;
   localparam int unsigned CDR_WORDS = 256;
   localparam int unsigned CDR_IDX_W = 8;
   localparam int unsigned CDR_ADDR_W = 11;

   // Organisation select codes: the shift of the address onto a word.
   localparam logic [1:0] CDR_ORG_256X16 = 2'h0;
   localparam logic [1:0] CDR_ORG_512X8 = 2'h1;
   localparam logic [1:0] CDR_ORG_1KX4 = 2'h2;
   localparam logic [1:0] CDR_ORG_2KX2 = 2'h3;

   // Operating mode codes.
   localparam logic [1:0] CDR_MODE_DUAL = 2'h0;
   localparam logic [1:0] CDR_MODE_SINGLE = 2'h1;
   localparam logic [1:0] CDR_MODE_LOOKUP = 2'h2;

   // Register byte offsets on the bus.
   localparam logic [7:0] CDR_OFF_CFG = 8'h00;
   localparam logic [7:0] CDR_OFF_LOAD = 8'h04;
   localparam logic [7:0] CDR_OFF_STATUS = 8'h08;

   // Field positions of the configuration register.
   localparam int unsigned CDR_CFG_MODE_LSB = 0;
   localparam int unsigned CDR_CFG_ORG_LSB = 2;
   localparam int unsigned CDR_CFG_SPLIT_BIT = 4;
   localparam int unsigned CDR_CFG_RDIN_BIT = 5;
   localparam int unsigned CDR_CFG_RDOUT_BIT = 6;
   localparam int unsigned CDR_CFG_RWADDR_BIT = 7;
   localparam int unsigned CDR_CFG_RWE_BIT = 8;
   localparam int unsigned CDR_CFG_RRADDR_BIT = 9;
   localparam int unsigned CDR_CFG_RRE_BIT = 10;
   localparam int unsigned CDR_CFG_W = 11;
   // Reset: dual port, 256 x 16, section clocking, every register in use.
   localparam logic [10:0] CDR_CFG_RESET = 11'h7e0;

   // Field positions of the load register.
   localparam int unsigned CDR_LOAD_DATA_LSB = 0;
   localparam int unsigned CDR_LOAD_IDX_LSB = 16;

   // Field positions of the status register.
   localparam int unsigned CDR_STAT_MODE_LSB = 16;
   localparam logic [15:0] CDR_WCOUNT_RESET = 16'h0000;

   // Bus answer codes.
   localparam logic CDR_HRESP_OKAY = 1'b0;

endpackage

// ==== rtl/cdr_store.sv ====
`timescale 1ns/10ps

// Flip-flop storage array with one masked write port and one read port.
module cdr_store
   import cdr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire logic [CDR_IDX_W-1:0] widx,
   input wire logic [CDR_WORD_W-1:0] wmask,
   input wire logic [CDR_WORD_W-1:0] wdata,
   input wire logic [CDR_IDX_W-1:0] ridx,
   output logic [CDR_WORD_W-1:0] rword
);

   // Stored words and their next values.
   logic [CDR_WORD_W-1:0] mem_q [CDR_WORDS];
   logic [CDR_WORD_W-1:0] mem_d [CDR_WORDS];

   ////////////////////////////////////////////////////////////////////////
   // One word per entry; only the masked lanes of the addressed word move.
   genvar gi;
   generate
      for (gi = 0; gi < CDR_WORDS; gi = gi + 1) begin : g_word
         // Merge the write lanes into the addressed entry.
         always_comb begin
            if (wr_en && widx == CDR_IDX_W'(gi)) begin
               mem_d[gi] = (mem_q[gi] & ~wmask) | (wdata & wmask);
            end else begin
               mem_d[gi] = mem_q[gi];
            end
         end
         // Contents are not reset; they keep their pattern through resets.
         always_ff @(posedge clk) begin
            mem_q[gi] <= mem_d[gi];
         end
      end
   endgenerate

   // The read port shows the stored word, so a write in the same cycle
   // becomes visible only after its edge.
   always_comb begin
      rword = mem_q[ridx];
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   chk_write_lands: assert property (
      wr_en |=> ((mem_q[$past(widx)] & $past(wmask)) ==
                 ($past(wdata) & $past(wmask))))
      else $error("Written lanes did not land in the array.");

   chk_collide_old: assert property (
      (wr_en && ridx == widx && ((wdata ^ rword) & wmask) != '0)
      |=> mem_q[$past(ridx)] != $past(rword))
      else $error("Colliding read did not show the older word.");

endmodule

// ==== rtl/cdr_ram.sv ====
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps

// What this block does
// - Holds 4096 storage bits for memory use.
// - Offers 256x16, 512x8, 1Kx4, 2Kx2 organisations.
// - Write and read sections run at own rates.
// - Separate clock enables for write and read.
// - Alternative: input registers, output registers clocked apart.
// - Each port register selectable or bypassed.
// - Port registers cleared asynchronously, three sources.
// - Write strobe generated internally from write clock.
// - Lookup mode: preloaded pattern, read only.
// - Lookup maps any 8-bit input to 16 bits.
// - Single-port mode shares one address for both.
// - Wider memories: blocks side by side.
// - Deeper memories: blocks cascaded, same timing.
// - Simultaneous two-port access needs two blocks.
module cdr_ram
   import cdr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic clr_local,
   input wire logic clr_global,
   input wire logic wr_ce,
   input wire logic rd_ce,
   input wire logic [CDR_ADDR_W-1:0] waddr,
   input wire logic [CDR_WORD_W-1:0] wdata,
   input wire logic we,
   input wire logic [CDR_ADDR_W-1:0] raddr,
   input wire logic re,
   output logic [CDR_WORD_W-1:0] rdata
);

   ////////////////////////////////////////////////////////////////////////
   // Bus slave state.

   // Address phase that was taken and waits for its data phase.
   logic aph_valid_q, aph_valid_d;
   logic aph_write_q, aph_write_d;
   logic [7:0] aph_addr_q, aph_addr_d;
   // Configuration register.
   logic [CDR_CFG_W-1:0] cfg_q, cfg_d;
   // Count of user writes that reached the array.
   logic [15:0] wcount_q, wcount_d;
   // Load request into the array from the bus.
   logic load_wr;

   // Fields of the configuration register.
   logic [1:0] mode;
   logic [1:0] org;
   logic split;
   logic use_din, use_dout, use_waddr, use_we, use_raddr, use_re;
   logic lookup, single;

   // The hsize bits are unused: only whole words are decoded.
   logic unused_size;

   always_comb begin
      mode = cfg_q[CDR_CFG_MODE_LSB +: 2];
      org = cfg_q[CDR_CFG_ORG_LSB +: 2];
      split = cfg_q[CDR_CFG_SPLIT_BIT];
      use_din = cfg_q[CDR_CFG_RDIN_BIT];
      use_dout = cfg_q[CDR_CFG_RDOUT_BIT];
      use_waddr = cfg_q[CDR_CFG_RWADDR_BIT];
      use_we = cfg_q[CDR_CFG_RWE_BIT];
      use_raddr = cfg_q[CDR_CFG_RRADDR_BIT];
      use_re = cfg_q[CDR_CFG_RRE_BIT];
      lookup = (mode == CDR_MODE_LOOKUP);
      single = (mode == CDR_MODE_SINGLE);
      unused_size = ^hsize;
   end

   // The slave never stretches a transfer and always answers OKAY.
   always_comb begin
      hreadyout = 1'b1;
      hresp = CDR_HRESP_OKAY;
   end

   // Take an address phase when selected and the bus is ready; the
   // data phase that follows writes or reads the latched register.
   always_comb begin
      aph_valid_d = aph_valid_q;
      aph_write_d = aph_write_q;
      aph_addr_d = aph_addr_q;
      if (hready) begin
         aph_valid_d = hsel && htrans[1];
         aph_write_d = hwrite;
         aph_addr_d = haddr[7:0];
      end
   end

   // Writes of the data phase; unmapped addresses are ignored.
   always_comb begin
      cfg_d = cfg_q;
      load_wr = 1'b0;
      if (aph_valid_q && aph_write_q) begin
         if (aph_addr_q == CDR_OFF_CFG) begin
            cfg_d = hwdata[CDR_CFG_W-1:0];
         end else if (aph_addr_q == CDR_OFF_LOAD) begin
            load_wr = 1'b1;
         end
      end
   end

   // Read mux over flip-flops; unmapped or reserved bits read as zero.
   always_comb begin
      hrdata = 32'h0000_0000;
      if (aph_valid_q && !aph_write_q) begin
         case (aph_addr_q)
            CDR_OFF_CFG: begin
               hrdata[CDR_CFG_W-1:0] = cfg_q;
            end
            CDR_OFF_STATUS: begin
               hrdata[15:0] = wcount_q;
               hrdata[CDR_STAT_MODE_LSB +: 2] = mode;
            end
            default: begin
               hrdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // Bus registers take the synchronous reset.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         aph_valid_q <= 1'b0;
         aph_write_q <= 1'b0;
         aph_addr_q <= 8'h00;
         cfg_q <= CDR_CFG_RESET;
         wcount_q <= CDR_WCOUNT_RESET;
      end else begin
         aph_valid_q <= aph_valid_d;
         aph_write_q <= aph_write_d;
         aph_addr_q <= aph_addr_d;
         cfg_q <= cfg_d;
         wcount_q <= wcount_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port registers and their clearing.

   // Any clear source empties the port registers at once.
   logic port_clr;
   always_comb begin
      port_clr = clr_local || clr_global || !reset_n;
   end

   // Enable of the read-address side: with split clocking the whole
   // input group follows the write enable, else the read enable.
   logic rin_ce;
   always_comb begin
      rin_ce = split ? wr_ce : rd_ce;
   end

   logic [CDR_WORD_W-1:0] din_q, din_d;
   logic [CDR_ADDR_W-1:0] waddr_q, waddr_d;
   logic we_q, we_d;
   logic [CDR_ADDR_W-1:0] raddr_q, raddr_d;
   logic re_q, re_d;
   logic [CDR_WORD_W-1:0] dout_q, dout_d;

   // Selected or bypassed values of each port.
   logic [CDR_WORD_W-1:0] din_p;
   logic [CDR_ADDR_W-1:0] waddr_p, raddr_p;
   logic we_p, re_p;
   logic [CDR_WORD_W-1:0] rsel;

   // Input registers load only while their section is enabled.
   always_comb begin
      din_d = wr_ce ? wdata : din_q;
      waddr_d = wr_ce ? waddr : waddr_q;
      we_d = wr_ce ? we : we_q;
      raddr_d = rin_ce ? raddr : raddr_q;
      re_d = rin_ce ? re : re_q;
      dout_d = (rd_ce && re_p) ? rsel : dout_q;
   end

   // Each register is bypassed when its select bit is low.
   always_comb begin
      din_p = use_din ? din_q : wdata;
      waddr_p = use_waddr ? waddr_q : waddr;
      we_p = use_we ? we_q : we;
      re_p = use_re ? re_q : re;
      // One address serves both sides in single-port mode.
      if (single) begin
         raddr_p = waddr_p;
      end else begin
         raddr_p = use_raddr ? raddr_q : raddr;
      end
      rdata = use_dout ? dout_q : rsel;
   end

   // Port registers with their asynchronous clear.
   always_ff @(posedge clk or posedge port_clr) begin
      if (port_clr) begin
         din_q <= '0;
         waddr_q <= '0;
         we_q <= 1'b0;
         raddr_q <= '0;
         re_q <= 1'b0;
         dout_q <= '0;
      end else begin
         din_q <= din_d;
         waddr_q <= waddr_d;
         we_q <= we_d;
         raddr_q <= raddr_d;
         re_q <= re_d;
         dout_q <= dout_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address mapping onto the 16-bit words.

   // Lookup mode always reads whole 16-bit words on an 8-bit index.
   logic [1:0] eff_org;
   always_comb begin
      eff_org = lookup ? CDR_ORG_256X16 : org;
   end

   // Word index, bit offset and lane mask for one address.
   function automatic logic [CDR_IDX_W-1:0] word_idx(
      input logic [CDR_ADDR_W-1:0] a, input logic [1:0] o);
      logic [CDR_ADDR_W-1:0] s;
      s = a >> o;
      return s[CDR_IDX_W-1:0];
   endfunction

   function automatic logic [3:0] bit_off(
      input logic [CDR_ADDR_W-1:0] a, input logic [1:0] o);
      case (o)
         CDR_ORG_512X8: return {a[0], 3'h0};
         CDR_ORG_1KX4: return {a[1:0], 2'h0};
         CDR_ORG_2KX2: return {a[2:0], 1'h0};
         default: return 4'h0;
      endcase
   endfunction

   function automatic logic [CDR_WORD_W-1:0] lane_mask(input logic [1:0] o);
      case (o)
         CDR_ORG_512X8: return 16'h00ff;
         CDR_ORG_1KX4: return 16'h000f;
         CDR_ORG_2KX2: return 16'h0003;
         default: return 16'hffff;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Write strobe and array ports.

   // The strobe is made inside the block from the enabled write edge;
   // lookup mode refuses user writes and a bus load takes the port.
   logic wr_strobe;
   logic st_wr;
   logic [CDR_IDX_W-1:0] st_widx, st_ridx;
   logic [CDR_WORD_W-1:0] st_wmask, st_wdata, rword;
   logic [3:0] woff, roff;
   logic [CDR_WORD_W-1:0] lmask;

   always_comb begin
      wr_strobe = we_p && wr_ce && !lookup && !load_wr;
      lmask = lane_mask(eff_org);
      woff = bit_off(waddr_p, eff_org);
      roff = bit_off(raddr_p, eff_org);
      st_ridx = word_idx(raddr_p, eff_org);
      if (load_wr) begin
         st_wr = 1'b1;
         st_widx = hwdata[CDR_LOAD_IDX_LSB +: CDR_IDX_W];
         st_wmask = 16'hffff;
         st_wdata = hwdata[CDR_LOAD_DATA_LSB +: CDR_WORD_W];
      end else begin
         st_wr = wr_strobe;
         st_widx = word_idx(waddr_p, eff_org);
         st_wmask = CDR_WORD_W'(lmask << woff);
         st_wdata = CDR_WORD_W'((din_p & lmask) << woff);
      end
      rsel = CDR_WORD_W'(rword >> roff) & lmask;
   end

   // Count of user writes for software to observe.
   always_comb begin
      wcount_d = wr_strobe ? wcount_q + 16'h0001 : wcount_q;
   end

   cdr_store u_store (
      .clk(clk),
      .reset_n(reset_n),
      .wr_en(st_wr),
      .widx(st_widx),
      .wmask(st_wmask),
      .wdata(st_wdata),
      .ridx(st_ridx),
      .rword(rword)
   );

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   chk_count_follows: assert property (
      wr_strobe |=> wcount_q == $past(wcount_q) + 16'h0001)
      else $error("Write count did not follow the write strobe.");

   chk_lookup_ro: assert property (
      (lookup && !load_wr) |-> !st_wr)
      else $error("User write reached the array in lookup mode.");

   chk_clear_out: assert property (
      (clr_local || clr_global) |-> (dout_q == '0 && !we_q && !re_q))
      else $error("Port registers not cleared during a clear.");

   chk_single_addr: assert property (
      single |-> st_ridx == word_idx(waddr_p, eff_org))
      else $error("Single-port read used its own address.");

   sequence s_in_hold;
      split && !wr_ce && !port_clr;
   endsequence

   chk_split_hold: assert property (
      s_in_hold ##1 !port_clr |-> $stable(raddr_q) && $stable(waddr_q))
      else $error("Input registers moved while the input enable was low.");

   sequence s_rd_hold;
      !split && !rd_ce && !port_clr;
   endsequence

   chk_rd_stall: assert property (
      s_rd_hold ##1 !port_clr |-> $stable(raddr_q) && $stable(dout_q))
      else $error("Read section moved while its enable was low.");

   chk_load_word: assert property (
      (load_wr && aph_valid_q) |-> (st_wr && st_wmask == 16'hffff))
      else $error("Bus load did not write a whole word.");

   chk_bus_okay: assert property (
      aph_valid_q |-> (hreadyout && hresp == CDR_HRESP_OKAY))
      else $error("Bus answer was not a ready OKAY.");

endmodule

// ==== dv/cdr_user.sv ====
`timescale 1ns/10ps

// Behavioural user logic that drives the memory's user ports.
module cdr_user
   import cdr_pkg::*;
(
   input wire logic clk,
   output logic wr_ce,
   output logic rd_ce,
   output logic [CDR_ADDR_W-1:0] waddr,
   output logic [CDR_WORD_W-1:0] wdata,
   output logic we,
   output logic [CDR_ADDR_W-1:0] raddr,
   output logic re
);

   // Everything idle and both sections stalled at time zero.
   initial begin
      {wr_ce, rd_ce, we, re} = 4'h0;
      waddr = 11'h0;
      raddr = 11'h0;
      wdata = 16'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sets one cycle of user signals just after a rising edge.
   task automatic put(input logic w, input logic [10:0] wa,
      input logic [15:0] wd, input logic r, input logic [10:0] ra,
      input logic wc, input logic rc);
      @(posedge clk);
      we <= w;
      waddr <= wa;
      wdata <= wd;
      re <= r;
      raddr <= ra;
      wr_ce <= wc;
      rd_ce <= rc;
   endtask

   // Ends a transfer; stale data is shown inverted, never held.
   task automatic rest();
      @(posedge clk);
      we <= 1'b0;
      re <= 1'b0;
      wdata <= ~wdata;
   endtask

endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/10ps

// Compares a value and counts the outcome.
`define CHK(g, e) \
   begin \
      tests_run++; \
      if ((g) !== (e)) begin \
         failures++; \
         $display("Error %0t: got %h expected %h", $time, g, e); \
      end \
   end

// Self-checking bench for the configurable memory block.
module testbench
   import cdr_pkg::*;
;

   localparam logic [31:0] A_CFG = {24'h0, CDR_OFF_CFG};
   localparam logic [31:0] A_LOAD = {24'h0, CDR_OFF_LOAD};
   localparam logic [31:0] A_STAT = {24'h0, CDR_OFF_STATUS};

   logic clk;
   logic reset_n;
   logic hsel, hwrite, hready, hreadyout, hresp, clr_local, clr_global;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic wr_ce, rd_ce, we, re;
   logic [CDR_ADDR_W-1:0] waddr, raddr;
   logic [CDR_WORD_W-1:0] wdata, rdata;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;

   // The single slave's ready is the bus ready.
   assign hready = hreadyout;

   cdr_ram u_cdr_ram (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .clr_local,
      .clr_global, .wr_ce, .rd_ce, .waddr, .wdata, .we, .raddr, .re,
      .rdata);

   cdr_user u_user (.clk, .wr_ce, .rd_ce, .waddr, .wdata, .we, .raddr,
      .re);

   // A 25 MHz clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Cuts a hang short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("Compared %0d, mismatched %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One single AHB-Lite transfer; read data lands in rd.
   task automatic bus(input logic w, input logic [31:0] a,
      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   // A user write of one unit.
   task automatic wr(input logic [10:0] a, input logic [15:0] d);
      u_user.put(1'b1, a, d, 1'b0, a, 1'b1, 1'b1);
      u_user.rest();
   endtask

   // A read through a bypassed output, looked at once settled.
   task automatic rdc(input logic [10:0] a);
      u_user.put(1'b0, a, 16'h0, 1'b1, a, 1'b1, 1'b1);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Reset values, a read-only place and an unmapped place.
   task automatic t_reset();
      bus(1'b0, A_CFG, 32'h0);
      `CHK(rd[10:0], CDR_CFG_RESET)
      bus(1'b1, A_STAT, 32'h1234);
      bus(1'b0, A_STAT, 32'h0);
      `CHK(rd[17:0], 18'h0)
      bus(1'b0, 32'hc, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(hresp, CDR_HRESP_OKAY)
      $display("Test reset done");
   endtask

   // Bypassed ports: old word on a clash, stalled write section.
   task automatic t_bypass();
      bus(1'b1, A_CFG, 32'h0);
      wr(11'h5, 16'h1111);
      u_user.put(1'b1, 11'h5, 16'h2222, 1'b1, 11'h5, 1'b1, 1'b1);
      #1;
      `CHK(rdata, 16'h1111)
      u_user.rest();
      #1;
      `CHK(rdata, 16'h2222)
      u_user.put(1'b1, 11'h5, 16'h3333, 1'b1, 11'h5, 1'b0, 1'b1);
      u_user.rest();
      rdc(11'h5);
      `CHK(rdata, 16'h2222)
      bus(1'b0, A_STAT, 32'h0);
      `CHK(rd[15:0], 16'h2)
      $display("Test bypass done");
   endtask

   // Every organisation at its top two addresses, which share one word except in 256x16.
   task automatic t_orgs();
      logic [10:0] top;
      logic [15:0] m;
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, A_CFG, 32'(k) << CDR_CFG_ORG_LSB);
         top = 11'((256 << k) - 1);
         m = (16'h1 << (16 >> k)) - 16'h1;
         wr(top, 16'hffff);
         wr(top - 11'h1, 16'h0);
         rdc(top);
         `CHK(rdata & m, m)
         rdc(top - 11'h1);
         `CHK(rdata & m, 16'h0)
      end
      $display("Test organisations done");
   endtask

   // Preloaded table read by an 8-bit index; user writes refused.
   task automatic t_lookup();
      bus(1'b1, A_LOAD, 32'h00ff_beef);
      bus(1'b1, A_LOAD, 32'h0000_1357);
      bus(1'b1, A_CFG, 32'(CDR_MODE_LOOKUP));
      wr(11'h0ff, 16'h0);
      rdc(11'h7ff);
      `CHK(rdata, 16'hbeef)
      rdc(11'h0);
      `CHK(rdata, 16'h1357)
      bus(1'b0, A_STAT, 32'h0);
      `CHK(rd[17:16], CDR_MODE_LOOKUP)
      `CHK(rd[15:0], 16'h000a)
      $display("Test lookup done");
   endtask

   // All registers in use, stalls, clears and split clocking.
   task automatic t_regs();
      bus(1'b1, A_CFG, 32'(CDR_CFG_RESET));
      wr(11'h9, 16'h4444);
      wr(11'hb, 16'h5555);
      u_user.put(1'b0, 11'h9, 16'h0, 1'b1, 11'h9, 1'b1, 1'b1);
      repeat (2) @(posedge clk);
      #1;
      `CHK(rdata, 16'h4444)
      u_user.put(1'b0, 11'hb, 16'h0, 1'b1, 11'hb, 1'b1, 1'b1);
      #1;
      `CHK(rdata, 16'h4444)
      // The address register and the output register each add an edge.
      repeat (2) @(posedge clk);
      #1;
      `CHK(rdata, 16'h5555)
      u_user.put(1'b0, 11'h9, 16'h0, 1'b1, 11'h9, 1'b1, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      `CHK(rdata, 16'h5555)
      @(posedge clk);
      clr_local <= 1'b1;
      #1;
      `CHK(rdata, 16'h0)
      u_user.put(1'b0, 11'hb, 16'h0, 1'b1, 11'hb, 1'b1, 1'b1);
      clr_local <= 1'b0;
      repeat (2) @(posedge clk);
      clr_global <= 1'b1;
      #1;
      `CHK(rdata, 16'h0)
      u_user.put(1'b0, 11'h9, 16'h0, 1'b1, 11'h9, 1'b1, 1'b0);
      clr_global <= 1'b0;
      bus(1'b1, A_CFG, 32'(CDR_CFG_RESET) | 32'h10);
      repeat (3) @(posedge clk);
      #1;
      `CHK(rdata, 16'h0)
      u_user.put(1'b0, 11'h9, 16'h0, 1'b1, 11'h9, 1'b0, 1'b1);
      @(posedge clk);
      #1;
      `CHK(rdata, 16'h4444)
      $display("Test registers done");
   endtask

   // One address port serves the read as well.
   task automatic t_single();
      bus(1'b1, A_CFG, 32'(CDR_MODE_SINGLE));
      wr(11'h20, 16'h6666);
      u_user.put(1'b0, 11'h20, 16'h0, 1'b1, 11'h21, 1'b1, 1'b1);
      #1;
      `CHK(rdata, 16'h6666)
      $display("Test single done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: reset for ten cycles, then every scenario.
   initial begin
      reset_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      clr_local = 1'b0;
      clr_global = 1'b0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_bypass();
      t_orgs();
      t_lookup();
      t_regs();
      t_single();
      finish_test();
   end

endmodule
